// ---- include/wtr_pkg.sv ----
// Package of the sector-write command engine: register map, field layout,
// command codes, status and error bit positions, timing and geometry.
// Assumes a 40 MHz ref_clk and a host driving the plain register port.
package wtr_pkg;

  // Register indices on the host port
  localparam logic [3:0] WTR_REG_DATA    = 4'h0;
  localparam logic [3:0] WTR_REG_ERROR   = 4'h1;
  localparam logic [3:0] WTR_REG_SECCNT  = 4'h2;
  localparam logic [3:0] WTR_REG_SECNUM  = 4'h3;
  localparam logic [3:0] WTR_REG_CYLLO   = 4'h4;
  localparam logic [3:0] WTR_REG_CYLHI   = 4'h5;
  localparam logic [3:0] WTR_REG_DRVHEAD = 4'h6;
  localparam logic [3:0] WTR_REG_STATCMD = 4'h7;
  localparam logic [3:0] WTR_REG_MULT    = 4'h8;
  localparam logic [3:0] WTR_REG_IRQSTAT = 4'h9;
  localparam logic [3:0] WTR_REG_IRQEN   = 4'ha;
  localparam logic [3:0] WTR_REG_IRQCLR  = 4'hb;

  // Command codes
  localparam logic [7:0] WTR_CMD_WRITE      = 8'h30;
  localparam logic [7:0] WTR_CMD_WRITE_NR   = 8'h31;
  localparam logic [7:0] WTR_CMD_WRITE_NOER = 8'h38;
  localparam logic [7:0] WTR_CMD_VERIFY     = 8'h3c;
  localparam logic [7:0] WTR_CMD_MULT       = 8'hc5;
  localparam logic [7:0] WTR_CMD_MULT_NOER  = 8'hcd;

  // Status bit positions
  localparam int WTR_ST_BUSY  = 7;
  localparam int WTR_ST_DEVICE_READY_FLAG  = 6;
  localparam int WTR_ST_DWF   = 5;
  localparam int WTR_ST_DSC   = 4;
  localparam int WTR_ST_DRQ   = 3;
  localparam int WTR_ST_DATA_FIXED_FLAG  = 2;
  localparam int WTR_ST_ERR   = 0;
  // Error bit positions
  localparam int WTR_ER_BBK   = 7;
  localparam int WTR_ER_UNC   = 6;
  localparam int WTR_ER_ID_NOT_FOUND_FLAG  = 4;
  localparam int WTR_ER_COMMAND_ABORTED_FLAG  = 2;
  localparam int WTR_ER_ADDRESS_MARK_MISSING_FLAG  = 0;
  // Drive/head field positions
  localparam int WTR_DH_LBA   = 6;
  localparam int WTR_DH_DRV   = 4;
  // Interrupt event positions
  localparam int WTR_EV_DONE  = 0;
  localparam int WTR_EV_BLOCK = 1;
  localparam int WTR_EV_ERROR = 2;
  localparam int WTR_EV_W     = 3;

  // Reset values
  localparam logic [7:0] WTR_SECCNT_RST  = 8'h01;
  localparam logic [7:0] WTR_SECNUM_RST  = 8'h01;
  localparam logic [7:0] WTR_MULT_RST    = 8'h00;
  localparam logic [2:0] WTR_IRQEN_RST   = 3'h0;

  // Last word index of a sector in 16-bit words, and full-count value for a zero count
  localparam logic [7:0] WTR_LAST_WORD   = 8'hff;
  localparam logic [8:0] WTR_FULL_COUNT  = 9'h100;

  // CHS geometry used when stepping addresses
  localparam logic [7:0] WTR_SECT_PER_TRK = 8'h3f;
  localparam logic [3:0] WTR_LAST_HEAD    = 4'hf;

  // Busy must rise within this time after a command is taken
  localparam int WTR_CLK_MHZ      = 40;
  localparam int WTR_BUSY_MAX_NS  = 400;
  localparam int WTR_BUSY_MAX_CYC = (WTR_BUSY_MAX_NS * WTR_CLK_MHZ) / 1000;

  typedef struct packed {
    logic        lba;
    logic        drive;
    logic [3:0]  head;
    logic [15:0] cyl;
    logic [7:0]  sect;
  } wtr_addr_t;

  // Program request towards the flash back end
  typedef struct packed {
    logic      valid;
    logic      no_erase;
    logic      verify;
    wtr_addr_t addr;
  } wtr_media_req_t;

  // Outcome of one sector program
  typedef struct packed {
    logic done;
    logic bad_block_flag;
    logic uncorrectable_flag;
    logic id_not_found_flag;
    logic address_mark_missing_flag;
    logic wfault;
  } wtr_media_rsp_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        we;
    logic        re;
  } wtr_bus_req_t;

endpackage : wtr_pkg

// ---- verification/testbench.sv ----
// Self-checking bench for the sector-write engine.
// Assumes the flash model answers each program; host cycles go through wr/rd.
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin mismatches++; \
  $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end

module testbench import wtr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic           ref_clk;
  logic           arst_n;
  wtr_bus_req_t   bus_req;
  logic [15:0]    bus_rdata;
  logic [15:0]    rd_v;
  logic [15:0]    word_sum;
  wtr_media_req_t media_req;
  wtr_media_req_t last_req;
  logic [7:0]     media_rd_idx;
  logic [15:0]    media_rd_word;
  wtr_media_rsp_t media_rsp;
  logic           irq;
  logic           fail;
  logic [9:0]     wait_cyc;
  int             mismatches;
  int             n_compared;
  logic [7:0]     cmds [2] = '{8'h38, 8'h3c};

  wtr_sector_write i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .media_req(media_req), .media_rd_idx(media_rd_idx), .media_rd_word(media_rd_word),
    .media_rsp(media_rsp), .irq(irq));

  wtr_flash_model i_flash (.ref_clk(ref_clk), .arst_n(arst_n), .media_req(media_req),
    .media_rd_idx(media_rd_idx), .media_rd_word(media_rd_word), .media_rsp(media_rsp),
    .wait_cyc(wait_cyc), .fail(fail), .last_req(last_req), .word_sum(word_sum));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic finish_test();
    $display("mismatches %0d compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  // One idle edge before each strobe keeps strobes from being reassigned in one step
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge ref_clk);
    bus_req <= '0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: 16'h0000, we: 1'b0, re: 1'b1};
    @(posedge ref_clk);
    bus_req <= '0;
    #1 d = bus_rdata;
  endtask : rd

  task automatic chk_rd(input logic [3:0] a, input logic [15:0] exp);
    rd(a, rd_v);
    `CHK(rd_v, exp)
  endtask : chk_rd

  task automatic wait_st(input logic [15:0] mask, input logic [15:0] val);
    for (int i = 0; i < 300; i++) begin
      rd(WTR_REG_STATCMD, rd_v);
      if ((rd_v & mask) === val) return;
    end
    mismatches++;
    $display("unexpected at %0t: status wait timed out", $time);
  endtask : wait_st

  task automatic sector(input logic [15:0] base);
    for (int i = 0; i < 256; i++) wr(WTR_REG_DATA, base + 16'(i));
  endtask : sector

  task automatic task_file(input logic [7:0] cnt, input logic [7:0] sn, input logic [15:0] cyl,
                           input logic [7:0] dh);
    wr(WTR_REG_SECCNT, {8'h00, cnt});
    wr(WTR_REG_SECNUM, {8'h00, sn});
    wr(WTR_REG_CYLLO, {8'h00, cyl[7:0]});
    wr(WTR_REG_CYLHI, {8'h00, cyl[15:8]});
    wr(WTR_REG_DRVHEAD, {8'h00, dh});
  endtask : task_file

  function automatic logic [15:0] exp_sum(input logic [15:0] s);
    return {s[7:0], 8'h00} + 16'h7f80;
  endfunction : exp_sum

  initial begin
    #2ms;
    mismatches++;
    $display("unexpected at %0t: watchdog expired", $time);
    finish_test();
  end

  initial begin
    arst_n   = 1'b0;
    bus_req  = '0;
    fail     = 1'b0;
    wait_cyc = 10'd300;
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk_rd(WTR_REG_SECCNT, 16'h0001);
    chk_rd(WTR_REG_SECNUM, 16'h0001);
    chk_rd(WTR_REG_MULT, 16'h0000);
    chk_rd(WTR_REG_STATCMD, 16'h0050);
    chk_rd(4'hc, 16'h0000);
    // Two CHS sectors, interrupts enabled
    wr(WTR_REG_IRQEN, 16'h0007);
    task_file(8'h02, 8'h05, 16'h0102, 8'h03);
    wr(WTR_REG_STATCMD, 16'h0030);
    wait_st(16'h0088, 16'h0008);
    `CHK(irq, 1'b0)
    sector(16'h1000);
    chk_rd(WTR_REG_STATCMD, 16'h0080);
    `CHK(last_req.addr, wtr_addr_t'{lba: 1'b0, drive: 1'b0, head: 4'h3, cyl: 16'h0102, sect: 8'h05})
    `CHK(last_req.no_erase, 1'b0)
    wait_st(16'h0088, 16'h0008);
    sector(16'h1100);
    wait_st(16'h0088, 16'h0000);
    `CHK(irq, 1'b1)
    `CHK(word_sum, exp_sum(16'h1100))
    chk_rd(WTR_REG_SECNUM, 16'h0007);
    chk_rd(WTR_REG_SECCNT, 16'h0000);
    chk_rd(WTR_REG_IRQSTAT, 16'h0003);
    wr(WTR_REG_IRQCLR, 16'h0007);
    chk_rd(WTR_REG_IRQSTAT, 16'h0000);
    `CHK(irq, 1'b0)
    // Zero count, LBA, failure on the second sector
    task_file(8'h00, 8'h01, 16'h0000, 8'h40);
    wr(WTR_REG_STATCMD, 16'h0031);
    wait_st(16'h0088, 16'h0008);
    sector(16'h2000);
    wait_st(16'h0088, 16'h0008);
    chk_rd(WTR_REG_SECCNT, 16'h00ff);
    fail <= 1'b1;
    sector(16'h2100);
    wait_st(16'h0089, 16'h0001);
    chk_rd(WTR_REG_ERROR, 16'h0080);
    chk_rd(WTR_REG_SECNUM, 16'h0002);
    chk_rd(WTR_REG_SECCNT, 16'h00ff);
    rd(WTR_REG_IRQSTAT, rd_v);
    `CHK(rd_v[WTR_EV_ERROR], 1'b1)
    fail <= 1'b0;
    // Multiple-mode codes refused while the block size is unset
    for (int k = 0; k < 2; k++) begin
      wr(WTR_REG_IRQCLR, 16'h0007);
      wr(WTR_REG_STATCMD, (k == 0) ? 16'h00cd : 16'h0038);
      wait_st(16'h0089, 16'h0001);
      chk_rd(WTR_REG_ERROR, 16'h0004);
      chk_rd(WTR_REG_STATCMD, 16'h0051);
      chk_rd(WTR_REG_IRQSTAT, 16'h0001);
    end
    wr(WTR_REG_IRQCLR, 16'h0007);
    // Three sectors in blocks of two; targets taken as already erased
    wr(WTR_REG_MULT, 16'h0002);
    task_file(8'h03, 8'h0a, 16'h0000, 8'h40);
    wr(WTR_REG_STATCMD, 16'h00cd);
    for (int k = 0; k < 3; k++) begin
      wait_st(16'h0088, 16'h0008);
      if (k > 0) chk_rd(WTR_REG_IRQSTAT, (k == 2) ? 16'h0002 : 16'h0000);
      sector(16'h4000);
    end
    wait_st(16'h0088, 16'h0000);
    `CHK(last_req.no_erase, 1'b1)
    chk_rd(WTR_REG_IRQSTAT, 16'h0003);
    wr(WTR_REG_IRQCLR, 16'h0007);
    // No-erase single block and write-verify, prompt back end
    wait_cyc <= 10'd260;
    wr(WTR_REG_MULT, 16'h0001);
    for (int k = 0; k < 2; k++) begin
      task_file(8'h01, 8'h20, 16'h0000, 8'h40);
      wr(WTR_REG_STATCMD, {8'h00, cmds[k]});
      wait_st(16'h0088, 16'h0008);
      sector(16'h3000);
      wait_st(16'h0089, 16'h0000);
      `CHK(last_req.no_erase, (k == 0))
      `CHK(last_req.verify, (k == 1))
      `CHK(word_sum, exp_sum(16'h3000))
      chk_rd(WTR_REG_ERROR, 16'h0000);
      chk_rd(WTR_REG_STATCMD, 16'h0050);
    end
    finish_test();
  end
endmodule : testbench

// ---- verification/wtr_flash_model.sv ----
// Behavioural flash back end for the sector-write engine.
// Assumes one program request at a time; reads the whole buffer, then answers.
module wtr_flash_model (
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    arst_n,
  // Engine side
  input  wire wtr_pkg::wtr_media_req_t media_req,
  output logic [7:0]                   media_rd_idx,
  input  wire logic [15:0]             media_rd_word,
  output wtr_pkg::wtr_media_rsp_t      media_rsp,
  // Bench control and observation
  input  wire logic [9:0]              wait_cyc,
  input  wire logic                    fail,
  output wtr_pkg::wtr_media_req_t      last_req,
  output logic [15:0]                  word_sum
);
  timeunit 1ns;
  timeprecision 1ps;
  import wtr_pkg::*;

  logic       busy_q;
  logic [9:0] cnt_q;

  // Must be at least 256 so every buffer word is summed before the answer
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_q    <= 1'b0;
      cnt_q     <= 10'h000;
      last_req  <= '0;
      word_sum  <= 16'h0000;
      media_rsp <= '0;
    end else begin
      media_rsp <= '0;
      if (media_req.valid) begin
        busy_q   <= 1'b1;
        cnt_q    <= 10'h000;
        last_req <= media_req;
        word_sum <= 16'h0000;
      end else if (busy_q) begin
        cnt_q <= cnt_q + 10'h001;
        if (cnt_q >= 10'h001 && cnt_q <= 10'h100) begin
          word_sum <= word_sum + media_rd_word;
        end
        if (cnt_q == wait_cyc) begin
          busy_q    <= 1'b0;
          media_rsp <= {1'b1, fail, 4'h0};
        end
      end
    end
  end

  assign media_rd_idx = cnt_q[7:0];
endmodule : wtr_flash_model

// ---- verilog/wtr_sector_write.sv ----
// Sector-write command engine: task-file registers, 512-byte sector buffer,
// busy/data-request sequencing, per-block and completion interrupts.
// Assumes a host on the plain register port and a flash back end that
// reads the buffer by word index and answers each program with one pulse.
// What this block does
// RL1: Command CDh runs multiple-mode write, skipping erase before each sector.
// RL2: Command 38h writes sectors with multiple behaviour and no implied erase.
// RL3: Host should pre-erase targets before either no-erase write command.
// RL4: Commands 30h/31h write 1 to 256 sectors; count zero means 256.
// RL5: Transfer starts at sector number, cylinder and head registers.
// RL6: On acceptance assert busy, then data request with busy clear.
// RL7: No interrupt announces the first data transfer of a command.
// RL8: Host moves no data until busy is seen clear.
// RL9: Full sector sets busy and clears data request until next buffer ready.
// RL10: On completion clear busy and raise an interrupt.
// RL11: On error stop at failing sector, leaving its address in registers.
// RL12: Host may read registers afterwards to find error and sector.
// RL13: Command 3Ch verifies each sector right after writing it.
// RL14: Only the error and status bits valid for the command are reported.
// RL15: Multiple mode interrupts once per block; last partial block takes remainder.
// RL16: Multiple write aborts when block size unset or multiple mode disabled.
// RL17: Busy rises within 400 ns of a multiple write being taken.
// RL18: Each sector moves 256 sixteen-bit words per data-request interval.
//
// The address map and the strobed register port were decided locally.
module wtr_sector_write (
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    arst_n,
  // Host register port
  input  wire wtr_pkg::wtr_bus_req_t   bus_req,
  output logic [15:0]                  bus_rdata,
  // Flash back end
  output wtr_pkg::wtr_media_req_t      media_req,
  input  wire logic [7:0]              media_rd_idx,
  output logic [15:0]                  media_rd_word,
  input  wire wtr_pkg::wtr_media_rsp_t media_rsp,
  // Interrupt
  output logic                         irq
);
  import wtr_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_ACCEPT, ST_DRQ, ST_PROG} wtr_state_t;

  logic             rst_s1_q;
  logic             rst_n_q;
  wtr_state_t       state_q;
  wtr_addr_t        addr_q;
  logic [7:0]       seccnt_q;
  logic [7:0]       feature_q;
  logic [7:0]       mult_q;
  logic [7:0]       err_q;
  logic             err_st_q;
  logic             dwf_q;
  logic [7:0]       cmd_q;
  logic [8:0]       remain_q;
  logic [7:0]       blk_left_q;
  logic [7:0]       word_q;
  logic [15:0]      sbuf_q [0:255];
  logic [WTR_EV_W-1:0] irq_st_q;
  logic [WTR_EV_W-1:0] irq_en_q;
  logic [WTR_EV_W-1:0] ev;
  logic             cmd_wr;
  logic             cmd_known;
  logic             cmd_multi;
  logic             cmd_ok;
  logic             cmd_abort;
  logic             data_wr;
  logic             sect_full;
  logic             rsp_ok;
  logic             rsp_bad;
  logic             last_sect;
  logic             blk_end;
  logic             busy;
  logic             data_request_flag;
  logic [7:0]       status;

  function automatic logic is_write(input logic [7:0] c);
    return c == WTR_CMD_WRITE || c == WTR_CMD_WRITE_NR || c == WTR_CMD_VERIFY ||
           c == WTR_CMD_WRITE_NOER || c == WTR_CMD_MULT || c == WTR_CMD_MULT_NOER;
  endfunction : is_write

  // 38h behaves as a multiple write, so it shares the block size checks
  function automatic logic is_multi(input logic [7:0] c);
    return c == WTR_CMD_WRITE_NOER || c == WTR_CMD_MULT || c == WTR_CMD_MULT_NOER;
  endfunction : is_multi

  // Error bits meaningful for a command; unknown codes report abort only
  function automatic logic [7:0] err_valid(input logic [7:0] c);
    logic [7:0] m;
    m = 8'h00;
    m[WTR_ER_COMMAND_ABORTED_FLAG] = 1'b1;
    if (is_write(c)) begin
      m[WTR_ER_BBK]  = 1'b1;
      m[WTR_ER_ID_NOT_FOUND_FLAG] = 1'b1;
      m[WTR_ER_ADDRESS_MARK_MISSING_FLAG] = 1'b1;
    end
    return m;
  endfunction : err_valid

  function automatic wtr_addr_t addr_next(input wtr_addr_t a);
    wtr_addr_t n;
    n = a;
    if (a.lba) begin
      {n.head, n.cyl, n.sect} = {a.head, a.cyl, a.sect} + 28'h0000001;
    end else if (a.sect >= WTR_SECT_PER_TRK) begin
      n.sect = 8'h01;
      if (a.head == WTR_LAST_HEAD) begin
        n.head = 4'h0;
        n.cyl  = a.cyl + 16'h0001;
      end else begin
        n.head = a.head + 4'h1;
      end
    end else begin
      n.sect = a.sect + 8'h01;
    end
    return n;
  endfunction : addr_next

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  assign cmd_wr    = bus_req.we && bus_req.addr == WTR_REG_STATCMD && state_q == ST_IDLE;
  assign cmd_known = is_write(bus_req.wdata[7:0]);
  assign cmd_multi = is_multi(bus_req.wdata[7:0]);
  assign cmd_abort = cmd_wr && (!cmd_known || (cmd_multi && mult_q == 8'h00)); // [RL16]
  assign cmd_ok    = cmd_wr && !cmd_abort;
  assign data_wr   = bus_req.we && bus_req.addr == WTR_REG_DATA && state_q == ST_DRQ;
  assign sect_full = data_wr && word_q == WTR_LAST_WORD; // [RL18]
  assign rsp_bad   = state_q == ST_PROG && media_rsp.done &&
                     (media_rsp.bad_block_flag || media_rsp.uncorrectable_flag || media_rsp.id_not_found_flag || media_rsp.address_mark_missing_flag || media_rsp.wfault);
  assign rsp_ok    = state_q == ST_PROG && media_rsp.done && !rsp_bad;
  assign last_sect = remain_q == 9'h001;
  assign blk_end   = blk_left_q == 8'h01;

  // Busy while taking a command or programming; data request only when open
  assign busy = state_q == ST_ACCEPT || state_q == ST_PROG; // [RL6] [RL9]
  assign data_request_flag  = state_q == ST_DRQ;

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (cmd_ok) begin
            state_q <= ST_ACCEPT; // [RL6] [RL17]
          end
        end
        ST_ACCEPT: state_q <= ST_DRQ; // [RL6]
        ST_DRQ: begin
          if (sect_full) begin
            state_q <= ST_PROG; // [RL9]
          end
        end
        ST_PROG: begin
          if (rsp_bad || (rsp_ok && last_sect)) begin
            state_q <= ST_IDLE; // [RL10] [RL11]
          end else if (rsp_ok) begin
            state_q <= ST_DRQ;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  function automatic logic [7:0] mult_q_or_one(input logic [7:0] c);
    return is_multi(c) ? mult_q : 8'h01;
  endfunction : mult_q_or_one

  // Command code, sector and block counters
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cmd_q      <= 8'h00;
      remain_q   <= 9'h000;
      blk_left_q <= 8'h00;
    end else if (cmd_ok) begin
      cmd_q      <= bus_req.wdata[7:0];
      remain_q   <= (seccnt_q == 8'h00) ? WTR_FULL_COUNT : {1'b0, seccnt_q}; // [RL4]
      blk_left_q <= cmd_multi ? mult_q : 8'h01; // [RL15]
    end else if (rsp_ok) begin
      remain_q   <= remain_q - 9'h001;
      blk_left_q <= blk_end ? mult_q_or_one(cmd_q) : blk_left_q - 8'h01; // [RL15]
    end
  end

  // Word pointer into the sector buffer
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      word_q <= 8'h00;
    end else if (state_q == ST_ACCEPT || rsp_ok) begin
      word_q <= 8'h00;
    end else if (data_wr) begin
      word_q <= word_q + 8'h01; // [RL18]
    end
  end

  // Sector buffer; the back end reads it while the engine waits busy
  always_ff @(posedge ref_clk) begin
    if (data_wr) begin
      sbuf_q[word_q] <= bus_req.wdata;
    end
    media_rd_word <= sbuf_q[media_rd_idx];
  end

  // Task-file registers; address only advances after a good sector
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      addr_q    <= '0;
      addr_q.sect <= WTR_SECNUM_RST;
      seccnt_q  <= WTR_SECCNT_RST;
      feature_q <= 8'h00;
      mult_q    <= WTR_MULT_RST;
    end else if (rsp_ok) begin
      addr_q   <= addr_next(addr_q);
      seccnt_q <= seccnt_q - 8'h01;
    end else if (bus_req.we && state_q == ST_IDLE) begin
      case (bus_req.addr)
        WTR_REG_ERROR:   feature_q   <= bus_req.wdata[7:0];
        WTR_REG_SECCNT:  seccnt_q    <= bus_req.wdata[7:0];
        WTR_REG_SECNUM:  addr_q.sect <= bus_req.wdata[7:0];
        WTR_REG_CYLLO:   addr_q.cyl[7:0]  <= bus_req.wdata[7:0];
        WTR_REG_CYLHI:   addr_q.cyl[15:8] <= bus_req.wdata[7:0];
        WTR_REG_DRVHEAD: begin
          addr_q.lba   <= bus_req.wdata[WTR_DH_LBA];
          addr_q.drive <= bus_req.wdata[WTR_DH_DRV];
          addr_q.head  <= bus_req.wdata[3:0];
        end
        WTR_REG_MULT:    mult_q      <= bus_req.wdata[7:0];
        default: ;
      endcase
    end
  end

  // Error and fault reporting, masked to what the command defines
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      err_q    <= 8'h00;
      err_st_q <= 1'b0;
      dwf_q    <= 1'b0;
    end else if (cmd_abort) begin
      err_q    <= 8'h01 << WTR_ER_COMMAND_ABORTED_FLAG;
      err_st_q <= 1'b1;
      dwf_q    <= 1'b0;
    end else if (cmd_ok) begin
      err_q    <= 8'h00;
      err_st_q <= 1'b0;
      dwf_q    <= 1'b0;
    end else if (rsp_bad) begin
      // Uncorrectable is not defined for writes and is dropped here
      err_q    <= {media_rsp.bad_block_flag, media_rsp.uncorrectable_flag, 1'b0, media_rsp.id_not_found_flag,
                   3'h0, media_rsp.address_mark_missing_flag} & err_valid(cmd_q); // [RL14] [RL12]
      err_st_q <= 1'b1;
      dwf_q    <= media_rsp.wfault;
    end
  end

  // Corrected-data bit is never valid for a write and reads zero
  always_comb begin
    status = 8'h00;
    status[WTR_ST_BUSY] = busy;
    status[WTR_ST_DEVICE_READY_FLAG] = !busy;
    status[WTR_ST_DWF]  = dwf_q;
    status[WTR_ST_DSC]  = !busy;
    status[WTR_ST_DRQ]  = data_request_flag;
    status[WTR_ST_DATA_FIXED_FLAG] = 1'b0; // [RL14]
    status[WTR_ST_ERR]  = err_st_q;
  end

  // One program request per full sector, no erase for the no-erase codes
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      media_req <= '0;
    end else begin
      media_req.valid    <= sect_full; // [RL9]
      media_req.no_erase <= cmd_q == WTR_CMD_WRITE_NOER || cmd_q == WTR_CMD_MULT_NOER; // [RL1] [RL2]
      media_req.verify   <= cmd_q == WTR_CMD_VERIFY; // [RL13]
      media_req.addr     <= addr_q; // [RL5]
    end
  end

  // Events: completion, start of each later block, error stop
  always_comb begin
    ev = '0;
    ev[WTR_EV_DONE]  = (rsp_ok && last_sect) || cmd_abort; // [RL10]
    ev[WTR_EV_BLOCK] = rsp_ok && !last_sect && blk_end; // [RL15] [RL7]
    ev[WTR_EV_ERROR] = rsp_bad; // [RL11]
  end

  // Sticky status; a new event outranks a clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_st_q <= '0;
      irq_en_q <= WTR_IRQEN_RST;
    end else begin
      if (bus_req.we && bus_req.addr == WTR_REG_IRQEN) begin
        irq_en_q <= bus_req.wdata[WTR_EV_W-1:0];
      end
      if (bus_req.we && bus_req.addr == WTR_REG_IRQCLR) begin
        irq_st_q <= (irq_st_q & ~bus_req.wdata[WTR_EV_W-1:0]) | ev;
      end else begin
        irq_st_q <= irq_st_q | ev;
      end
    end
  end

  assign irq = |(irq_st_q & irq_en_q);

  // Read data stand in the cycle after the strobe only
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      bus_rdata <= 16'h0000;
    end else if (bus_req.re) begin
      case (bus_req.addr)
        WTR_REG_ERROR:   bus_rdata <= {8'h00, err_q};
        WTR_REG_SECCNT:  bus_rdata <= {8'h00, seccnt_q};
        WTR_REG_SECNUM:  bus_rdata <= {8'h00, addr_q.sect};
        WTR_REG_CYLLO:   bus_rdata <= {8'h00, addr_q.cyl[7:0]};
        WTR_REG_CYLHI:   bus_rdata <= {8'h00, addr_q.cyl[15:8]};
        WTR_REG_DRVHEAD: bus_rdata <= {8'h00, 1'b1, addr_q.lba, 1'b1, addr_q.drive, addr_q.head}; // [RL12]
        WTR_REG_STATCMD: bus_rdata <= {8'h00, status};
        WTR_REG_MULT:    bus_rdata <= {8'h00, mult_q};
        WTR_REG_IRQSTAT: bus_rdata <= {13'h0000, irq_st_q};
        WTR_REG_IRQEN:   bus_rdata <= {13'h0000, irq_en_q};
        default:         bus_rdata <= 16'h0000;
      endcase
    end else begin
      bus_rdata <= 16'h0000;
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n_q);

  busy_after_cmd_a: assert property (cmd_ok |=> busy ##1 (data_request_flag && !busy)) // [RL6]
    else $error("busy then data request not seen after command");
  busy_in_time_a: assert property (cmd_ok && cmd_multi |-> ##[1:16] busy) // [RL17]
    else $error("busy late after multiple write");
  no_first_irq_a: assert property ((state_q == ST_ACCEPT) |-> ev == '0 ##1 ev == '0) // [RL7]
    else $error("interrupt event at first transfer");
  drq_busy_excl_a: assert property (!(busy && data_request_flag)) // [RL9]
    else $error("busy and data request together");
  sector_words_a: assert property ($rose(state_q == ST_PROG) |-> $past(word_q) == WTR_LAST_WORD) // [RL18]
    else $error("sector ended before 256 words");
  done_irq_a: assert property (rsp_ok && last_sect |=> !busy && irq_st_q[WTR_EV_DONE]) // [RL10]
    else $error("completion without interrupt");
  err_stop_a: assert property (rsp_bad |=> state_q == ST_IDLE && $stable(addr_q) && err_st_q) // [RL11]
    else $error("error did not stop at failing sector");
  abort_multi_a: assert property (cmd_wr && cmd_multi && mult_q == 8'h00 |=> // [RL16]
                                  !busy && !data_request_flag && err_q[WTR_ER_COMMAND_ABORTED_FLAG])
    else $error("multiple write without block size not aborted");
  zero_count_a: assert property (cmd_ok && seccnt_q == 8'h00 |=> remain_q == WTR_FULL_COUNT) // [RL4]
    else $error("zero count not taken as 256");
  no_erase_a: assert property (media_req.valid && (cmd_q == WTR_CMD_MULT_NOER || cmd_q == WTR_CMD_WRITE_NOER) // [RL1] [RL2]
                               |-> media_req.no_erase)
    else $error("no-erase command asked for erase");
  verify_a: assert property (media_req.valid |-> media_req.verify == (cmd_q == WTR_CMD_VERIFY)) // [RL13]
    else $error("verify flag wrong");
  start_addr_a: assert property (media_req.valid |-> media_req.addr == addr_q) // [RL5]
    else $error("program address differs from registers");
  unc_masked_a: assert property (is_write(cmd_q) |-> !err_q[WTR_ER_UNC] && !status[WTR_ST_DATA_FIXED_FLAG]) // [RL14]
    else $error("undefined bit reported");

  multi_block_c: cover property (ev[WTR_EV_BLOCK]);
  full_write_c:  cover property (rsp_ok && last_sect && remain_q == 9'h001);
  error_stop_c:  cover property (rsp_bad && !last_sect);
  abort_c:       cover property (cmd_abort);

endmodule : wtr_sector_write
